// ==== shared/ulb_regs.vh ====
`ifndef ULB_REGS_VH
`define ULB_REGS_VH
// ==================================================
// register byte offsets
`define ULB_OFF_MODE 12'h000
`define ULB_OFF_CTRL 12'h004
`define ULB_OFF_DIV 12'h008
`define ULB_OFF_TXBUF 12'h00c
`define ULB_OFF_RXBUF 12'h010
`define ULB_OFF_TXST 12'h014
`define ULB_OFF_RXERR 12'h018
`define ULB_OFF_IRQ 12'h01c
// ==================================================
// mode register fields
`define ULB_M_POWER 7
`define ULB_M_TXE 6
`define ULB_M_RXE 5
`define ULB_M_PAR_HI 4
`define ULB_M_PAR_LO 3
`define ULB_M_LEN8 2
`define ULB_M_STOP2 1
`define ULB_M_MERGE 0
// ==================================================
// control register fields
`define ULB_C_BRF 7
`define ULB_C_BRT 6
`define ULB_C_BTT 5
`define ULB_C_BL_HI 4
`define ULB_C_BL_LO 2
`define ULB_C_DIR 1
`define ULB_C_INV 0
// ==================================================
// status bits, parity codes, constants
`define ULB_TS_FULL 1
`define ULB_TS_SHIFT 0
`define ULB_PAR_NONE 2'h0
`define ULB_PAR_ZERO 2'h1
`define ULB_PAR_ODD 2'h2
`define ULB_PAR_EVEN 2'h3
`define ULB_DIV_RESET 8'h82
`define ULB_RXBUF_RESET 8'hff
`define ULB_BRK_BASE 5'h0d
`define ULB_BRK_OK 5'h0b
`endif

// ==== rtl/ulb_uart.v ====
// Behaviour
// - buffer accepts next byte once shifting starts
// - tx status bit 1 is buffer full
// - tx status bit 0 is shift active
// - receive sampling needs power then enable
// - falling edge, recheck after divisor, start
// - shift bits, stop raises done, copy
// - parity error reported at frame end
// - receiver checks only one stop bit
// - parity, framing and overrun flags
// - reading error status clears it
// - error irq separate or merged by bit 0
// - two agreeing samples update filtered input
// - power drives line high; trigger sends break
// - break 13 to 20 bits, done, self clear
// - after break return idle normal mode
// - break receive enable arms detection
// - long break: done irq, flags cleared
// - short break: no irq, flags kept
// - frame format, order and inversion
// - bit time is twice divisor clocks
// - power off resets status and line
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "ulb_regs.vh"
module ulb_uart (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg tx_done_irq,
  output reg rx_done_irq,
  output reg rx_error_irq
);
  // ==================================================
  // registers and apb decode
  reg [7:0] op_mode_reg;
  reg [7:0] serial_control_reg;
  reg [7:0] baud_divisor_reg;
  reg [7:0] tx_buffer;
  reg [7:0] rx_buffer;
  reg tx_buf_full_flag;
  reg tx_shift_active_flag;
  reg overrun_flag;
  reg parity_err_flag;
  reg framing_err_flag;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire pwr = op_mode_reg[`ULB_M_POWER];
  wire txen = pwr && op_mode_reg[`ULB_M_TXE];
  wire rxen = pwr && op_mode_reg[`ULB_M_RXE];
  wire [1:0] par = op_mode_reg[`ULB_M_PAR_HI:`ULB_M_PAR_LO];
  wire len8 = op_mode_reg[`ULB_M_LEN8];
  wire msb_first = serial_control_reg[`ULB_C_DIR];
  wire [3:0] ndata = len8 ? 4'h8 : 4'h7;
  wire par_on = (par != `ULB_PAR_NONE);
  wire txbuf_wr = wr && paddr == `ULB_OFF_TXBUF && txen;
  wire rxerr_rd = rd && paddr == `ULB_OFF_RXERR;
  wire rxbuf_rd = rd && paddr == `ULB_OFF_RXBUF;
  // ==================================================
  // noise filter: two-flop sync then match detector
  reg rx_s1, rx_s2, rx_m, rx_f;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_m <= 1'b1;
      rx_f <= 1'b1;
    end else begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_m <= rx_s2;
      if (!pwr) begin
        rx_m <= 1'b1;
        rx_f <= 1'b1;
      end else if (rx_s2 == rx_m) begin
        rx_f <= rx_m;
      end
    end
  end
  // ==================================================
  // transmitter
  localparam TX_IDLE = 2'h0;
  localparam TX_DATA = 2'h1;
  localparam TX_BRK = 2'h2;
  reg [1:0] tx_st;
  reg [8:0] tx_cnt;
  reg [10:0] tx_sh;
  reg [4:0] tx_bits;
  reg tx_line;
  wire [8:0] half = {1'b0, baud_divisor_reg};
  wire [8:0] bit_clks = {baud_divisor_reg, 1'b0};
  wire tx_tick = (tx_cnt == bit_clks - 9'h001);
  reg [7:0] txd;
  reg tx_par;
  integer i;
  always @* begin
    txd = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (msb_first)
        txd[i] = tx_buffer[(len8 ? 7 : 6) - i];
      else
        txd[i] = tx_buffer[i];
    end
    if (!len8)
      txd[7] = 1'b0;
    case (par)
      `ULB_PAR_EVEN: tx_par = ^txd;
      `ULB_PAR_ODD: tx_par = ~^txd;
      default: tx_par = 1'b0;
    endcase
  end
  wire [4:0] stop_n = op_mode_reg[`ULB_M_STOP2] ? 5'h2 : 5'h1;
  wire [4:0] frame_bits = 5'h1 + {1'b0, ndata} + {4'h0, par_on} + stop_n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 9'h000;
      tx_sh <= 11'h7ff;
      tx_bits <= 5'h00;
      tx_line <= 1'b1;
      tx_buf_full_flag <= 1'b0;
      tx_shift_active_flag <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      if (!txen) begin
        tx_st <= TX_IDLE;
        tx_cnt <= 9'h000;
        tx_line <= 1'b1;
        tx_buf_full_flag <= 1'b0;
        tx_shift_active_flag <= 1'b0;
      end else begin
        if (txbuf_wr)
          tx_buf_full_flag <= 1'b1;
        tx_cnt <= tx_tick ? 9'h000 : tx_cnt + 9'h001;
        case (tx_st)
          TX_IDLE: begin
            if (tx_buf_full_flag) begin
              // load shifter, free buffer at once for back to back
              tx_sh <= {2'b11, tx_par, txd};
              // 7-bit frames put parity at bit 7, so bit 8 is a stop bit
              if (!par_on || !len8)
                tx_sh[8] <= 1'b1;
              if (!len8)
                tx_sh[7] <= par_on ? tx_par : 1'b1;
              tx_line <= 1'b0;
              tx_bits <= frame_bits - 5'h1;
              tx_cnt <= 9'h000;
              tx_st <= TX_DATA;
              tx_shift_active_flag <= 1'b1;
              tx_buf_full_flag <= txbuf_wr;
            end else if (serial_control_reg[`ULB_C_BTT]) begin
              tx_line <= 1'b0;
              tx_bits <= `ULB_BRK_BASE +
                {2'b00, serial_control_reg[`ULB_C_BL_HI:`ULB_C_BL_LO]};
              tx_cnt <= 9'h000;
              tx_st <= TX_BRK;
              tx_shift_active_flag <= 1'b1;
            end
          end
          TX_DATA: begin
            if (tx_tick) begin
              if (tx_bits == 5'h00) begin
                tx_st <= TX_IDLE;
                tx_shift_active_flag <= 1'b0;
                tx_done_irq <= 1'b1;
              end else begin
                tx_line <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[10:1]};
                tx_bits <= tx_bits - 5'h01;
              end
            end
          end
          TX_BRK: begin
            if (tx_tick) begin
              if (tx_bits == 5'h01) begin
                tx_line <= 1'b1;
                tx_st <= TX_IDLE;
                tx_shift_active_flag <= 1'b0;
                tx_done_irq <= 1'b1;
              end
              tx_bits <= tx_bits - 5'h01;
            end
          end
          default: tx_st <= TX_IDLE;
        endcase
      end
    end
  end
  wire brk_clr = (tx_st == TX_BRK) && tx_tick && tx_bits == 5'h01;
  // ==================================================
  // receiver
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_BRK = 2'h3;
  reg [1:0] rx_st;
  reg [8:0] rx_cnt;
  reg [3:0] rx_idx;
  reg [8:0] rx_shifter;
  reg rx_prev;
  reg [4:0] brk_len;
  reg rx_done_set;
  wire rx_fall = rx_prev && !rx_f;
  wire rx_tick = (rx_cnt == bit_clks - 9'h001);
  wire [3:0] nbits = ndata + {3'h0, par_on};
  wire brk_arm = serial_control_reg[`ULB_C_BRT];
  reg [7:0] rxd;
  reg rx_perr;
  integer j;
  always @* begin
    rxd = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
      if (msb_first)
        rxd[j] = rx_shifter[(len8 ? 7 : 6) - j];
      else
        rxd[j] = rx_shifter[j];
    end
    if (!len8)
      rxd[7] = 1'b0;
    case (par)
      `ULB_PAR_EVEN: rx_perr = ^rxd ^ rx_shifter[ndata];
      `ULB_PAR_ODD: rx_perr = ~(^rxd ^ rx_shifter[ndata]);
      default: rx_perr = 1'b0;
    endcase
  end
  wire rx_stop = (rx_st == RX_DATA) && rx_tick && rx_idx == nbits;
  wire brk_end = (rx_st == RX_BRK) && rx_tick && rx_f;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 9'h000;
      rx_idx <= 4'h0;
      rx_shifter <= 9'h1ff;
      rx_prev <= 1'b1;
      brk_len <= 5'h00;
      rx_buffer <= `ULB_RXBUF_RESET;
      overrun_flag <= 1'b0;
      parity_err_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      rx_done_set <= 1'b0;
    end else begin
      rx_prev <= rx_f;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      if (rxbuf_rd)
        rx_done_set <= 1'b0;
      if (rxerr_rd) begin
        overrun_flag <= 1'b0;
        parity_err_flag <= 1'b0;
        framing_err_flag <= 1'b0;
      end
      rx_cnt <= rx_tick ? 9'h000 : rx_cnt + 9'h001;
      if (!pwr) begin
        rx_st <= RX_IDLE;
        rx_buffer <= `ULB_RXBUF_RESET;
        overrun_flag <= 1'b0;
        parity_err_flag <= 1'b0;
        framing_err_flag <= 1'b0;
        rx_done_set <= 1'b0;
      end else if (!rxen) begin
        rx_st <= RX_IDLE;
      end else begin
        case (rx_st)
          RX_IDLE: begin
            if (rx_fall) begin
              rx_cnt <= 9'h000;
              rx_st <= RX_START;
            end
          end
          RX_START: begin
            if (rx_cnt == half - 9'h001) begin
              rx_cnt <= 9'h000;
              rx_idx <= 4'h0;
              brk_len <= 5'h01;
              if (rx_f)
                rx_st <= RX_IDLE;
              else
                rx_st <= brk_arm ? RX_BRK : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tick) begin
              if (rx_idx == nbits) begin
                // only one stop bit checked, second ignored
                rx_st <= RX_IDLE;
                rx_done_irq <= 1'b1;
                if (rx_done_set)
                  overrun_flag <= 1'b1;
                else begin
                  rx_buffer <= rxd;
                  rx_done_set <= 1'b1;
                end
                if (rx_perr)
                  parity_err_flag <= 1'b1;
                if (!rx_f)
                  framing_err_flag <= 1'b1;
                if (rx_done_set || rx_perr || !rx_f) begin
                  rx_error_irq <= !op_mode_reg[`ULB_M_MERGE];
                end
              end else begin
                rx_shifter[rx_idx] <= rx_f;
                rx_idx <= rx_idx + 4'h1;
              end
            end
          end
          RX_BRK: begin
            if (rx_tick) begin
              if (rx_f) begin
                rx_st <= RX_IDLE;
                if (brk_len >= `ULB_BRK_OK)
                  rx_done_irq <= 1'b1;
              end else if (brk_len != 5'h1f) begin
                brk_len <= brk_len + 5'h01;
              end
            end
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end
  wire brk_ok = brk_end && brk_len >= `ULB_BRK_OK;
  // ==================================================
  // apb slave, control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode_reg <= 8'h00;
      serial_control_reg <= 8'h00;
      baud_divisor_reg <= `ULB_DIV_RESET;
      tx_buffer <= 8'h00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      pready <= psel && !pready;
      pslverr <= 1'b0;
      serial_out_pin <= serial_control_reg[`ULB_C_INV] ? ~tx_line : tx_line;
      if (!txen)
        serial_out_pin <= 1'b1;
      if (psel && !pready) begin
        prdata <= 32'h00000000;
        case (paddr)
          `ULB_OFF_MODE: prdata[7:0] <= op_mode_reg;
          `ULB_OFF_CTRL: prdata[7:0] <= serial_control_reg;
          `ULB_OFF_DIV: prdata[7:0] <= baud_divisor_reg;
          `ULB_OFF_TXBUF: prdata[7:0] <= tx_buffer;
          `ULB_OFF_RXBUF: prdata[7:0] <= rx_buffer;
          `ULB_OFF_TXST:
            prdata[1:0] <= {tx_buf_full_flag, tx_shift_active_flag};
          `ULB_OFF_RXERR:
            prdata[2:0] <= {parity_err_flag, framing_err_flag, overrun_flag};
          default: pslverr <= 1'b1;
        endcase
      end
      if (wr) begin
        case (paddr)
          `ULB_OFF_MODE: op_mode_reg <= pwdata[7:0];
          `ULB_OFF_CTRL: serial_control_reg <= pwdata[7:0];
          `ULB_OFF_DIV: baud_divisor_reg <= pwdata[7:0];
          `ULB_OFF_TXBUF: if (txen) tx_buffer <= pwdata[7:0];
          default: ;
        endcase
      end
      if (wr && paddr == `ULB_OFF_CTRL && pwdata[`ULB_C_BRT] && rxen)
        serial_control_reg[`ULB_C_BRF] <= 1'b1;
      if (brk_clr)
        serial_control_reg[`ULB_C_BTT] <= 1'b0;
      if (brk_ok) begin
        serial_control_reg[`ULB_C_BRF] <= 1'b0;
        serial_control_reg[`ULB_C_BRT] <= 1'b0;
      end
      if (!pwr) begin
        serial_control_reg[`ULB_C_BRF] <= 1'b0;
        serial_control_reg[`ULB_C_BRT] <= 1'b0;
      end
    end
  end
endmodule // ulb_uart

// ==== testbench/ulb_uart_monitor.sv ====
`timescale 1ns/1ns
// ==========
// port-level checks
module ulb_uart_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire serial_out_pin,
  input wire tx_done_irq,
  input wire rx_done_irq,
  input wire rx_error_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer)
    else $error("setup not answered next cycle");
  property p_rdy_in_access;
    pready |-> psel && penable;
  endproperty
  a_rdy_in_access: assert property (p_rdy_in_access)
    else $error("ready outside access phase");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready held too long");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("slave error without ready");
  property p_tx_irq;
    tx_done_irq |=> !tx_done_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx done not a pulse");
  // no two frames can finish closer than a fraction of a bit
  sequence s_rx_quiet;
    !rx_done_irq [*8];
  endsequence
  property p_rx_irq;
    rx_done_irq |=> s_rx_quiet;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx done repeats too soon");
  property p_err_irq;
    rx_error_irq |-> rx_done_irq;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error irq apart from frame end");
  property p_bit_hold;
    $fell(serial_out_pin) |=> !serial_out_pin [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("low level shorter than a bit");
endmodule // ulb_uart_monitor

bind ulb_uart ulb_uart_monitor ulb_uart_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
  .rx_error_irq(rx_error_irq)
);

// ==== testbench/ulb_node.sv ====
`timescale 1ns/1ns
// ==========
// remote node, 8 data bits, lsb first
module ulb_node #(
  parameter BIT = 16
) (
  input wire pclk,
  input wire line_in,
  output reg line_out
);
  reg [7:0] got[$];
  reg [7:0] d;
  integer i;
  initial line_out = 1'b1;
  // start bit at index 0; one idle cycle after so calls never collide
  task send(input [11:0] b, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      line_out <= b[k];
      repeat (BIT) @(posedge pclk);
    end
    line_out <= 1'b1;
    @(posedge pclk);
  endtask
  // mid-bit sampling; breaks show up as zero bytes
  initial forever begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      d[i] = line_in;
    end
    got.push_back(d);
    repeat (BIT) @(posedge pclk);
  end
endmodule // ulb_node

// ==== testbench/test_ulb_uart.sv ====
`timescale 1ns/1ns
`include "ulb_regs.vh"
// ==========
// bench
module test_ulb_uart;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire rxd;
  wire txd;
  wire tx_done_irq;
  wire rx_done_irq;
  wire rx_error_irq;
  reg [31:0] r;
  reg e;
  int failures = 0;
  int samples_checked = 0;
  int n_tx = 0;
  int n_rx = 0;
  int n_er = 0;
  ulb_uart ulb_uart_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(rxd),
    .serial_out_pin(txd), .tx_done_irq(tx_done_irq),
    .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq)
  );
  ulb_node #(.BIT(16)) ulb_node_inst (
    .pclk(pclk), .line_in(txd), .line_out(rxd)
  );
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // non-blocking counts so waiters read them without a race
  always @(posedge pclk) begin
    if (tx_done_irq === 1'b1) n_tx <= n_tx + 1;
    if (rx_done_irq === 1'b1) n_rx <= n_rx + 1;
    if (rx_error_irq === 1'b1) n_er <= n_er + 1;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    results;
  end
  // ==========
  // helpers
  task results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits for ready however long it takes; only the watchdog ends a hang
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [11:0] a, input [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task wt(input int s, input int v);
    int k;
    for (k = 0; k < 5000 && (s ? n_rx : n_tx) < v; k++) @(posedge pclk);
    chk(s ? n_rx : n_tx, v);
  endtask
  // ==========
  // scenarios
  task t_reset;
    rd(`ULB_OFF_TXST, 32'h0);
    rd(`ULB_OFF_RXBUF, `ULB_RXBUF_RESET);
    rd(`ULB_OFF_DIV, `ULB_DIV_RESET);
    apb(1'b0, `ULB_OFF_IRQ, 32'h0);
    chk(e, 1'b1);
  endtask
  task t_tx;
    int k;
    wr(`ULB_OFF_DIV, 32'h8);
    wr(`ULB_OFF_MODE, 32'h84);
    chk(txd, 1'b1);
    wr(`ULB_OFF_MODE, 32'he4);
    wr(`ULB_OFF_TXBUF, 32'h55);
    for (k = 0; k < 50; k++) begin
      apb(1'b0, `ULB_OFF_TXST, 32'h0);
      if (r[1] === 1'b0) break;
    end
    chk(r, 32'h1);
    wr(`ULB_OFF_TXBUF, 32'ha3);
    rd(`ULB_OFF_TXST, 32'h3);
    wt(0, 2);
    rd(`ULB_OFF_TXST, 32'h0);
    chk(ulb_node_inst.got[0], 32'h55);
    chk(ulb_node_inst.got[1], 32'ha3);
  endtask
  task t_brk_tx;
    int k;
    int n;
    wr(`ULB_OFF_CTRL, 32'h2c);
    for (k = 0; k < 100 && txd !== 1'b0; k++) @(posedge pclk);
    for (n = 0; n < 1000 && txd === 1'b0; n++) @(posedge pclk);
    chk(n, 16 * 16);
    wt(0, 3);
    rd(`ULB_OFF_CTRL, 32'h0c);
    repeat (50) @(posedge pclk);
    chk(txd, 1'b1);
    // lin: no back to back, status must read zero before each byte
    rd(`ULB_OFF_TXST, 32'h0);
    wr(`ULB_OFF_TXBUF, 32'h55);
    wt(0, 4);
    chk(ulb_node_inst.got[3], 32'h55);
  endtask
  task t_rx;
    ulb_node_inst.send({1'b1, 8'h3c, 1'b0}, 10);
    wt(1, 1);
    rd(`ULB_OFF_RXERR, 32'h0);
    rd(`ULB_OFF_RXBUF, 32'h3c);
    ulb_node_inst.send({1'b0, 8'h5a, 1'b0}, 10);
    wt(1, 2);
    chk(n_er, 1);
    rd(`ULB_OFF_RXERR, 32'h2);
    rd(`ULB_OFF_RXERR, 32'h0);
    rd(`ULB_OFF_RXBUF, 32'h5a);
    ulb_node_inst.send({1'b1, 8'h11, 1'b0}, 10);
    ulb_node_inst.send({1'b1, 8'h22, 1'b0}, 10);
    wt(1, 4);
    rd(`ULB_OFF_RXERR, 32'h1);
    rd(`ULB_OFF_RXBUF, 32'h11);
    wr(`ULB_OFF_MODE, 32'hfd);
    ulb_node_inst.send({2'b10, 8'h01, 1'b0}, 11);
    wt(1, 5);
    chk(n_er, 2);
    rd(`ULB_OFF_RXERR, 32'h4);
    rd(`ULB_OFF_RXBUF, 32'h01);
  endtask
  task t_brk_rx;
    wr(`ULB_OFF_CTRL, 32'h40);
    rd(`ULB_OFF_CTRL, 32'hc0);
    ulb_node_inst.send(12'h000, 12);
    wt(1, 6);
    rd(`ULB_OFF_CTRL, 32'h0);
    rd(`ULB_OFF_RXERR, 32'h0);
    rd(`ULB_OFF_RXBUF, 32'h01);
    wr(`ULB_OFF_CTRL, 32'h40);
    ulb_node_inst.send(12'h000, 9);
    repeat (400) @(posedge pclk);
    chk(n_rx, 6);
    rd(`ULB_OFF_CTRL, 32'hc0);
  endtask
  // msb first and inverted idle; 70 sent lsb first by the node is received as 0e msb first
  task t_fmt;
    wr(`ULB_OFF_CTRL, 32'h03);
    @(posedge pclk);
    chk(txd, 1'b0);
    ulb_node_inst.send({2'b11, 8'h70, 1'b0}, 11);
    wt(1, 7);
    rd(`ULB_OFF_RXERR, 32'h0);
    rd(`ULB_OFF_RXBUF, 32'h0e);
    wr(`ULB_OFF_CTRL, 32'h00);
    @(posedge pclk);
    chk(txd, 1'b1);
  endtask
  task t_power;
    rd(`ULB_OFF_TXST, 32'h0);
    wr(`ULB_OFF_MODE, 32'h0);
    rd(`ULB_OFF_TXST, 32'h0);
    rd(`ULB_OFF_RXBUF, `ULB_RXBUF_RESET);
    rd(`ULB_OFF_CTRL, 32'h0);
    chk(txd, 1'b1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_tx;
    t_brk_tx;
    t_rx;
    t_brk_rx;
    t_fmt;
    t_power;
    results;
  end
endmodule // test_ulb_uart
